// >>> verilog/rx_frame_mac.sv
/*
 * Receive frame MAC: preamble check, optional preamble forwarding,
 * CRC-32 check and strip, pad removal, frame screening in store-and-forward
 * mode only (cut-through passes every frame), statistics, APB register file.
 * Assumes one byte per pclk from same-clock PHY logic and at least
 * seven idle cycles after each terminate; the client never stalls.
 */
// The implementer's own choice: the APB interface to the registers.
// Overview of operation
// - filter register bit 0 picks cut-through or store-and-forward
// - cut-through mode buffers nothing and never drops a frame
// - runt frames are screened only while filter bit 3 is set
// - store-and-forward drops frames above the programmed maximum size
// - each screen (address, runt, oversize, pause, control, FCS) selectable
// - invalid frames screened per enabled criteria even when promiscuous
// - frame needs Start, six preamble bytes, SFD; otherwise ignored
// - Start arrives on lane 0; SFD 0xD5 ends the preamble
// - preamble stripped unless bit 0 of 0x125 forwards all eight bytes
// - CRC stripped while CRC config bit 1 set; set after reset
// - eop on last CRC byte when kept, last payload byte when stripped
// - FCS error rises with eop, unless pad removal moves eop to the payload end
// - CRC bits taken LSB first from each byte
// - CRC mismatch raises fcs_error, fcs_valid and error bit 1
// - FCS result delivered for every frame in cut-through, for kept frames only in store-and-forward
// - kept CRC bytes follow the last data byte directly
// - pad removal set at run time, off after reset
// - pad removal moves eop to payload end when length is 46 or less
// - stripped-pad frames never carry the CRC
// - FCS flags keep their unshifted timing under pad removal
// - statistics count the unstripped frame
`timescale 1ns/1ps
`default_nettype none
module rx_frame_mac (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire rxm_pkg::phy_byte_t phy_in,
  output rxm_pkg::beat_t rx_out
);

  // ********************************************************
  // storage
  // ********************************************************
  rxm_pkg::rx_state_t state, next_state;
  rxm_pkg::stage_t [rxm_pkg::DLY-1:0] dly;
  rxm_pkg::stage_t new_stage;
  rxm_pkg::beat_t beat;
  rxm_pkg::beat_t mem [0:rxm_pkg::BUF_DEPTH-1];
  logic [31:0] screen, pre_cfg, crc_cfg, pad_cfg, max_len, match_ctl;
  logic [31:0] st_lo, st_hi, frame_cnt, byte_cnt, crc;
  logic [2:0] pre_cnt, fl_cnt;
  logic [15:0] in_cnt, out_cnt, len_fld, opcode;
  logic [47:0] da_reg;
  logic first, cut, fcs_bad_q, runt_q, bad_q, drop_q, ovf_q;
  logic [rxm_pkg::BUF_AW:0] wr, cm, rd;

  // ********************************************************
  // APB decode
  // ********************************************************
  wire logic [9:0] idx = paddr[11:2];
  wire logic setup = psel && !penable;
  wire logic wr_en = psel && penable && pwrite;
  wire logic s_scr = idx == rxm_pkg::IDX_SCREEN;
  wire logic s_pre = idx == rxm_pkg::IDX_PRE;
  wire logic s_crc = idx == rxm_pkg::IDX_CRC;
  wire logic s_pad = idx == rxm_pkg::IDX_PAD;
  wire logic s_max = idx == rxm_pkg::IDX_MAXLEN;
  wire logic s_frm = idx == rxm_pkg::IDX_FRAMES;
  wire logic s_byt = idx == rxm_pkg::IDX_BYTES;
  wire logic s_mat = idx == rxm_pkg::IDX_MATCH;
  wire logic s_slo = idx == rxm_pkg::IDX_ST_LO;
  wire logic s_shi = idx == rxm_pkg::IDX_ST_HI;
  wire logic hit = s_scr || s_pre || s_crc || s_pad || s_max ||
                   s_frm || s_byt || s_mat || s_slo || s_shi;
  wire logic [31:0] rd_mux = s_scr ? screen :
                             s_pre ? pre_cfg :
                             s_crc ? crc_cfg :
                             s_pad ? pad_cfg :
                             s_max ? max_len :
                             s_frm ? frame_cnt :
                             s_byt ? byte_cnt :
                             s_mat ? match_ctl :
                             s_slo ? st_lo :
                             s_shi ? st_hi : 32'h0000_0000;

  // zero wait states; read data and error settle in the setup cycle
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata <= rd_mux;
      pslverr <= !hit;
    end
  end

  // writable registers; counters are read-only and ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      screen <= rxm_pkg::SCREEN_RST;
      pre_cfg <= rxm_pkg::ZERO_RST;
      crc_cfg <= rxm_pkg::CRC_RST;
      pad_cfg <= rxm_pkg::ZERO_RST;
      max_len <= rxm_pkg::MAXLEN_RST;
      match_ctl <= rxm_pkg::ZERO_RST;
      st_lo <= rxm_pkg::ZERO_RST;
      st_hi <= rxm_pkg::ZERO_RST;
    end else if (wr_en) begin
      if (s_scr) screen <= pwdata;
      if (s_pre) pre_cfg <= pwdata;
      if (s_crc) crc_cfg <= pwdata;
      if (s_pad) pad_cfg <= pwdata;
      if (s_max) max_len <= pwdata;
      if (s_mat) match_ctl <= pwdata;
      if (s_slo) st_lo <= pwdata;
      if (s_shi) st_hi <= pwdata;
    end
  end

  // ********************************************************
  // receive decode
  // ********************************************************
  wire logic cut_mode = screen[rxm_pkg::SCR_CUT];
  wire logic pre_fwd = pre_cfg[rxm_pkg::PRE_FWD];
  wire logic strip = crc_cfg[rxm_pkg::CRC_STRIP];
  wire logic pad_on = pad_cfg[rxm_pkg::PAD_EN];
  wire logic in_idle = state == rxm_pkg::ST_IDLE;
  wire logic in_pre = state == rxm_pkg::ST_PRE;
  wire logic in_body = state == rxm_pkg::ST_BODY;
  wire logic in_flush = state == rxm_pkg::ST_FLUSH;
  // start only counts on lane 0 of the byte stream
  wire logic is_start = in_idle && phy_in.ctrl &&
                        phy_in.data == rxm_pkg::START_CODE;
  wire logic pre_last = pre_cnt == rxm_pkg::PRE_LEN;
  wire logic [7:0] pre_want = pre_last ? rxm_pkg::SFD_BYTE :
                              rxm_pkg::PRE_BYTE;
  wire logic pre_good = !phy_in.ctrl && phy_in.data == pre_want;
  wire logic pre_fail = in_pre && !pre_good;
  wire logic push_data = in_body && !phy_in.ctrl;
  wire logic term = in_body && phy_in.ctrl;
  wire logic pre_push = pre_fwd && (is_start || (in_pre && pre_good));
  wire logic tail = term || in_flush;
  wire logic [2:0] step = term ? 3'h0 : fl_cnt;
  wire logic shift = push_data || pre_push || tail;
  wire rxm_pkg::stage_t head = dly[rxm_pkg::DLY-1];

  // the newest four bytes at terminate are the CRC
  wire logic over_strip = tail && strip &&
                          step > rxm_pkg::EOP_STRIP;
  wire logic emit = shift && head.valid && !over_strip && !cut;
  wire logic short_len = len_fld <= rxm_pkg::PAD_MAX_LEN;
  wire logic pad_hit = emit && pad_on && short_len && !head.pre &&
                       out_cnt == rxm_pkg::LEN_BASE + len_fld;
  // unshifted end of frame, ignores any pad cut
  wire logic end_evt = tail && step == (strip ? rxm_pkg::EOP_STRIP :
                       rxm_pkg::EOP_KEEP);
  wire logic fcs_bad = crc != rxm_pkg::CRC_RESIDUE;

  // ********************************************************
  // frame verdict
  // ********************************************************
  wire logic runt = in_cnt < rxm_pkg::RUNT_MIN;
  wire logic over = in_cnt > max_len[15:0];
  wire logic ctl_frame = len_fld == rxm_pkg::CTRL_TYPE;
  wire logic pause = ctl_frame && opcode == rxm_pkg::PAUSE_OPC;
  wire logic [47:0] station = {st_hi[15:0], st_lo};
  wire logic da_bad = match_ctl[rxm_pkg::MATCH_EN] && da_reg != station &&
                      da_reg != rxm_pkg::BROADCAST;
  wire logic bad_term = phy_in.data != rxm_pkg::TERM_CODE;
  // each screen but the terminate check gated by its own bit; address screen by its own reg
  wire logic drop = !cut_mode && (
    da_bad || bad_term ||
    (screen[rxm_pkg::SCR_RUNT] && runt) ||
    (screen[rxm_pkg::SCR_OVER] && over) ||
    (screen[rxm_pkg::SCR_PAUSE] && pause) ||
    (screen[rxm_pkg::SCR_CTRL] && ctl_frame && !pause) ||
    (screen[rxm_pkg::SCR_FCS] && fcs_bad));

  // ********************************************************
  // store-and-forward buffer control
  // ********************************************************
  wire logic full = (wr - rd) == rxm_pkg::BUF_DEPTH;
  wire logic wr_beat = emit || end_evt;
  wire logic ovf_now = ovf_q || (wr_beat && full);
  wire logic saf_wr = !cut_mode && wr_beat && !ovf_now;
  wire logic discard = drop_q || ovf_now;
  wire logic rd_go = rd != cm;
  wire logic [rxm_pkg::BUF_AW:0] wr_inc = {{rxm_pkg::BUF_AW{1'b0}}, saf_wr};

  // stage entering the delay line
  assign new_stage.valid = push_data || pre_push;
  assign new_stage.pre = pre_push;
  assign new_stage.data = phy_in.data;

  // client beat; FCS flags sit on the unshifted end
  assign beat.dv = emit;
  assign beat.sop = emit && first;
  assign beat.eop = emit && (end_evt || pad_hit);
  assign beat.fcs_valid = end_evt;
  assign beat.fcs_error = end_evt && fcs_bad_q;
  assign beat.error = end_evt ? {fcs_bad_q, runt_q || bad_q} : 2'h0;
  assign beat.data = head.data;

  // ********************************************************
  // sequencing
  // ********************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      rxm_pkg::ST_IDLE: if (is_start) next_state = rxm_pkg::ST_PRE;
      rxm_pkg::ST_PRE: begin
        if (pre_fail) next_state = rxm_pkg::ST_IDLE;
        else if (pre_last) next_state = rxm_pkg::ST_BODY;
      end
      rxm_pkg::ST_BODY: if (term) next_state = rxm_pkg::ST_FLUSH;
      rxm_pkg::ST_FLUSH: begin
        if (fl_cnt == rxm_pkg::EOP_KEEP) next_state = rxm_pkg::ST_IDLE;
      end
      default: next_state = rxm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= rxm_pkg::ST_IDLE;
      pre_cnt <= 3'h0;
      fl_cnt <= 3'h0;
    end else begin
      state <= next_state;
      pre_cnt <= in_pre ? pre_cnt + 3'h1 : 3'h0;
      fl_cnt <= tail ? step + 3'h1 : 3'h0;
    end
  end

  // eight-deep delay holds the preamble and keeps the CRC in reach
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) dly <= '0;
    else if (pre_fail) dly <= '0;
    else if (shift) dly <= {dly[rxm_pkg::DLY-2:0], new_stage};
  end

  // reflected CRC: bit 0 of each byte is the highest term
  function automatic logic [31:0] crc_step(input logic [31:0] c,
                                           input logic [7:0] d);
    logic [31:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r >> 1) ^ ((r[0] ^ d[i]) ? rxm_pkg::CRC_POLY : 32'h0);
    end
    return r;
  endfunction

  // per-frame header capture and CRC
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_cnt <= 16'h0000;
      crc <= rxm_pkg::CRC_INIT;
      da_reg <= 48'h0000_0000_0000;
      len_fld <= 16'h0000;
      opcode <= 16'h0000;
    end else if (is_start) begin
      in_cnt <= 16'h0000;
      crc <= rxm_pkg::CRC_INIT;
      len_fld <= 16'h0000;
      opcode <= 16'h0000;
    end else if (push_data) begin
      in_cnt <= in_cnt + 16'h0001;
      crc <= crc_step(crc, phy_in.data);
      if (in_cnt < rxm_pkg::DA_LEN) da_reg <= {da_reg[39:0], phy_in.data};
      if (in_cnt == rxm_pkg::LEN_HI) len_fld[15:8] <= phy_in.data;
      if (in_cnt == rxm_pkg::LEN_LO) len_fld[7:0] <= phy_in.data;
      if (in_cnt == rxm_pkg::OPC_HI) opcode[15:8] <= phy_in.data;
      if (in_cnt == rxm_pkg::OPC_LO) opcode[7:0] <= phy_in.data;
    end
  end

  // output position tracking and pad cut
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first <= 1'b0;
      cut <= 1'b0;
      out_cnt <= 16'h0000;
    end else if (is_start) begin
      first <= 1'b1;
      cut <= 1'b0;
      out_cnt <= 16'h0000;
    end else if (emit) begin
      first <= 1'b0;
      if (!head.pre) out_cnt <= out_cnt + 16'h0001;
      if (pad_hit) cut <= 1'b1;
    end
  end

  // verdict latched at terminate; statistics ignore pad removal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fcs_bad_q <= 1'b0;
      runt_q <= 1'b0;
      bad_q <= 1'b0;
      drop_q <= 1'b0;
      frame_cnt <= 32'h0000_0000;
      byte_cnt <= 32'h0000_0000;
    end else if (term) begin
      fcs_bad_q <= fcs_bad;
      runt_q <= runt && screen[rxm_pkg::SCR_RUNT];
      bad_q <= bad_term;
      drop_q <= drop;
      frame_cnt <= frame_cnt + 32'h0000_0001;
      byte_cnt <= byte_cnt + {16'h0000, in_cnt};
    end
  end

  // frame held until the verdict, then committed or rewound
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr <= '0;
      cm <= '0;
      rd <= '0;
      ovf_q <= 1'b0;
    end else begin
      if (is_start) ovf_q <= 1'b0;
      else if (wr_beat && full) ovf_q <= 1'b1;
      if (end_evt && discard) wr <= cm;
      else wr <= wr + wr_inc;
      if (end_evt && !discard) cm <= wr + wr_inc;
      if (rd_go) rd <= rd + 12'h001;
    end
  end

  // no reset on the array; only committed entries are read
  always_ff @(posedge pclk) begin
    if (saf_wr) mem[wr[rxm_pkg::BUF_AW-1:0]] <= beat;
  end

  // cut-through streams straight from the delay line
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) rx_out <= '0;
    else if (cut_mode) rx_out <= beat;
    else if (rd_go) rx_out <= mem[rd[rxm_pkg::BUF_AW-1:0]];
    else rx_out <= '0;
  end

  // ********************************************************
  // checks
  // ********************************************************
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  pre_abort_a: assert property (
    pre_fail |=> state == rxm_pkg::ST_IDLE && !dly[rxm_pkg::DLY-1].valid)
    else $error("bad preamble not ignored");
  sfd_body_a: assert property (
    in_pre && pre_last && pre_good |=> state == rxm_pkg::ST_BODY)
    else $error("SFD did not open the frame");
  strip_eop_a: assert property (
    cut_mode && emit && strip && term ##3 emit && !pad_on
    |=> rx_out.eop && rx_out.dv)
    else $error("eop not on last payload byte");
  fcs_mark_a: assert property (
    cut_mode && end_evt && fcs_bad_q
    |=> rx_out.fcs_error && rx_out.fcs_valid && rx_out.error[1])
    else $error("CRC mismatch not flagged");
  eop_fcs_a: assert property (
    cut_mode && end_evt && emit && !pad_hit |=> rx_out.eop && rx_out.fcs_valid)
    else $error("FCS flags not with eop");
  cut_quiet_a: assert property (
    pad_hit |=> !emit [*4])
    else $error("bytes delivered after pad cut");
  drop_over_a: assert property (
    term && !cut_mode && over && screen[rxm_pkg::SCR_OVER] |=> drop_q)
    else $error("oversized frame kept");
  runt_off_a: assert property (
    cut_mode && end_evt && !screen[rxm_pkg::SCR_RUNT] && !bad_q
    |=> !rx_out.error[0])
    else $error("runt flagged while screen off");
  stats_cnt_a: assert property (
    term |=> frame_cnt == $past(frame_cnt) + 32'h0000_0001)
    else $error("frame counter missed a frame");
  saf_drop_a: assert property (
    !cut_mode && end_evt && discard |=> wr == cm)
    else $error("dropped frame left in buffer");

endmodule
`default_nettype wire

// >>> common/rxm_pkg.sv
/*
 * Shared definitions of the receive frame MAC: register indices, field
 * positions, reset values, frame codes, timing figures and carriers.
 * Assumes a byte-wide receive stream and a 32-bit APB register port.
 */
package rxm_pkg;

  // ********************************************************
  // register indices (byte address is four times the index)
  // ********************************************************
  localparam logic [9:0] IDX_SCREEN = 10'h103;
  localparam logic [9:0] IDX_PRE = 10'h125;
  localparam logic [9:0] IDX_CRC = 10'h126;
  localparam logic [9:0] IDX_PAD = 10'h127;
  localparam logic [9:0] IDX_MAXLEN = 10'h128;
  localparam logic [9:0] IDX_FRAMES = 10'h129;
  localparam logic [9:0] IDX_BYTES = 10'h12A;
  localparam logic [9:0] IDX_MATCH = 10'h140;
  localparam logic [9:0] IDX_ST_LO = 10'h141;
  localparam logic [9:0] IDX_ST_HI = 10'h142;

  // ********************************************************
  // field positions and reset values
  // ********************************************************
  localparam int SCR_CUT = 32'h0;
  localparam int SCR_OVER = 32'h1;
  localparam int SCR_PAUSE = 32'h2;
  localparam int SCR_RUNT = 32'h3;
  localparam int SCR_CTRL = 32'h4;
  localparam int SCR_FCS = 32'h5;
  localparam int PRE_FWD = 32'h0;
  localparam int CRC_STRIP = 32'h1;
  localparam int PAD_EN = 32'h0;
  localparam int MATCH_EN = 32'h0;
  localparam logic [31:0] SCREEN_RST = 32'h0000_0000;
  localparam logic [31:0] CRC_RST = 32'h0000_0002;
  localparam logic [31:0] ZERO_RST = 32'h0000_0000;
  localparam logic [31:0] MAXLEN_RST = 32'h0000_05EE;

  // ********************************************************
  // frame codes and counts
  // ********************************************************
  localparam logic [7:0] START_CODE = 8'hFB;
  localparam logic [7:0] TERM_CODE = 8'hFD;
  localparam logic [7:0] PRE_BYTE = 8'h55;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [2:0] PRE_LEN = 3'h6;
  localparam int DLY = 32'h8;
  localparam logic [2:0] EOP_STRIP = 3'h3;
  localparam logic [2:0] EOP_KEEP = 3'h7;
  localparam logic [15:0] DA_LEN = 16'h0006;
  localparam logic [15:0] LEN_HI = 16'h000C;
  localparam logic [15:0] LEN_LO = 16'h000D;
  localparam logic [15:0] OPC_HI = 16'h000E;
  localparam logic [15:0] OPC_LO = 16'h000F;
  localparam logic [15:0] LEN_BASE = 16'h000D;
  localparam logic [15:0] PAD_MAX_LEN = 16'h002E;
  localparam logic [15:0] RUNT_MIN = 16'h0040;
  localparam logic [15:0] CTRL_TYPE = 16'h8808;
  localparam logic [15:0] PAUSE_OPC = 16'h0001;
  localparam logic [47:0] BROADCAST = 48'hFFFF_FFFF_FFFF;
  localparam logic [31:0] CRC_INIT = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB8_8320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB_20E3;
  localparam int BUF_AW = 32'hB;
  localparam logic [11:0] BUF_DEPTH = 12'h800;

  // ********************************************************
  // carriers
  // ********************************************************
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PRE = 4'b0010,
    ST_BODY = 4'b0100,
    ST_FLUSH = 4'b1000
  } rx_state_t;

  typedef struct packed {
    logic ctrl;
    logic [7:0] data;
  } phy_byte_t;

  typedef struct packed {
    logic valid;
    logic pre;
    logic [7:0] data;
  } stage_t;

  typedef struct packed {
    logic dv;
    logic sop;
    logic eop;
    logic fcs_valid;
    logic fcs_error;
    logic [1:0] error;
    logic [7:0] data;
  } beat_t;

endpackage

// >>> bench/phy_model.sv
/*
 * Receive-side source model: sends whole frames on the byte stream.
 * Assumes one caller at a time and the design on the same pclk.
 */
`timescale 1ns/1ps
`default_nettype none
module phy_model (
  input wire logic pclk,
  output var rxm_pkg::phy_byte_t phy_in
);
  // ******************************
  // frame source
  // ******************************
  initial phy_in = {1'b1, 8'h07};

  // start, six preamble, sfd, body, terminate, then varying idle codes
  task automatic send(input logic [7:0] f[$], input logic bad);
    @(posedge pclk) phy_in <= {1'b1, rxm_pkg::START_CODE};
    for (int i = 0; i < 6; i++) begin
      // one corrupted byte tests that a broken lead-in is ignored
      @(posedge pclk) phy_in <= {1'b0, (bad && i == 3) ? 8'h5D : 8'h55};
    end
    @(posedge pclk) phy_in <= {1'b0, rxm_pkg::SFD_BYTE};
    foreach (f[i]) begin
      @(posedge pclk) phy_in <= {1'b0, f[i]};
    end
    @(posedge pclk) phy_in <= {1'b1, rxm_pkg::TERM_CODE};
    // idle codes change each cycle so a stale byte never looks valid
    for (int i = 0; i < 12; i++) begin
      @(posedge pclk) phy_in <= {1'b1, 8'h07 ^ 8'(i)};
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/rx_frame_mac_tb.sv
/*
 * Self-checking bench of the receive frame MAC: APB master, frame
 * builder with its own CRC, queue of expected beats and a monitor.
 * Assumes phy_model as the source and a client that never stalls.
 */
`timescale 1ns/1ps
`default_nettype none
module rx_frame_mac_tb;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, pready, pslverr, er, strip = 1'b1;
  logic fwd = 1'b0, pad = 1'b0;
  logic [15:0] ty = 16'h0000, op = 16'h0000;
  logic [7:0] da = 8'hFF;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [15:0] rnd = 16'hB87A;
  logic [7:0] frm[$];
  logic [9:0] exp_q[$], exp_f[$];
  int error_cnt = 0, tests_run = 0, nfr = 0, nby = 0;
  rxm_pkg::phy_byte_t phy_in;
  rxm_pkg::beat_t rx_out;
  logic [11:0] ra[9] = '{12'h40C, 12'h494, 12'h498, 12'h49C, 12'h4A0,
    12'h4A4, 12'h4A8, 12'h500, 12'h7FC};
  logic [31:0] rv[9] = '{32'h0, 32'h0, 32'h2, 32'h0, 32'h5EE, 32'h0,
    32'h0, 32'h0, 32'h0};

  always #50 pclk = ~pclk;

  rx_frame_mac i_rx_frame_mac (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phy_in(phy_in), .rx_out(rx_out));
  phy_model phy (.pclk(pclk), .phy_in(phy_in));

  // ******************************
  // helpers
  // ******************************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // one transfer; read data and error taken at the completing edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("[FAIL] %0t apb timeout", $time);
      give_verdict();
    end
  endtask

  task cfg(input logic [31:0] s, p, c, d);
    apb(1'b1, 12'h40C, s);
    apb(1'b1, 12'h494, p);
    apb(1'b1, 12'h498, c);
    apb(1'b1, 12'h49C, d);
    fwd = p[0];
    strip = c[1];
    pad = d[0];
  endtask

  // builds a frame, notes its expected beats and flags, then sends it
  task automatic frame(input int p, mn, input logic bad, drop,
                       input logic [2:0] fl);
    logic [31:0] c;
    int last;
    frm = {};
    repeat (6) frm.push_back(da);
    repeat (6) begin
      rnd = lfsr(rnd);
      frm.push_back(rnd[7:0]);
    end
    frm.push_back(ty ? ty[15:8] : 8'(p >> 8));
    frm.push_back(ty ? ty[7:0] : 8'(p));
    if (ty) begin
      frm.push_back(op[15:8]);
      frm.push_back(op[7:0]);
    end
    repeat (p) begin
      rnd = lfsr(rnd);
      frm.push_back(rnd[7:0]);
    end
    while (frm.size() < mn) frm.push_back(8'h00);
    c = 32'hFFFF_FFFF;
    foreach (frm[i]) begin
      c = c ^ {24'h0, frm[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ rxm_pkg::CRC_POLY : c >> 1;
    end
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) frm.push_back(c[8*i +: 8]);
    nfr++;
    nby += frm.size();
    last = strip ? frm.size() - 5 : frm.size() - 1;
    if (pad && p <= 46) last = 13 + p;
    if (!drop) begin
      for (int k = 0; fwd && k < 8; k++)
        exp_q.push_back({k == 0, 1'b0, k == 0 ? 8'hFB : k == 7 ? 8'hD5 : 8'h55});
      for (int i = 0; i <= last; i++)
        exp_q.push_back({i == 0 && !fwd, i == last, frm[i]});
      exp_f.push_back({7'h0, fl});
    end
    phy.send(frm, 1'b0);
  endtask

  // bounded drain, then a quiet spell that exposes stray beats
  task automatic step(input string s);
    int n;
    n = 0;
    while ((exp_q.size() || exp_f.size()) && n < 4000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 4000) begin
      error_cnt++;
      $display("[FAIL] %0t drain timeout", $time);
      give_verdict();
    end
    repeat (20) @(posedge pclk);
    $display("test %s done", s);
  endtask

  // ******************************
  // monitor and main sequence
  // ******************************
  // outputs are registered, so the falling edge sees settled values
  always @(negedge pclk) if (presetn) begin
    if (rx_out.dv === 1'b1)
      chk({rx_out.sop, rx_out.eop, rx_out.data}, exp_q.size() ? exp_q.pop_front() : 'x);
    if (rx_out.fcs_valid === 1'b1)
      chk({rx_out.fcs_error, rx_out.error}, exp_f.size() ? exp_f.pop_front() : 'x);
    if (rx_out.fcs_valid === 1'b1 && !pad)
      chk({31'h0, rx_out.eop}, 32'h1);
  end

  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, rv[i]);
      chk({31'h0, er}, {31'h0, i == 8});
    end
    apb(1'b1, 12'h4A4, 32'hFFFF_FFFF);
    step("registers");
    cfg(32'h1, 32'h0, 32'h2, 32'h0);
    frame(40, 60, 1'b0, 1'b0, 3'h0);
    frame(40, 60, 1'b1, 1'b0, 3'h6);
    step("cut-through");
    cfg(32'h1, 32'h0, 32'h0, 32'h0);
    frame(50, 60, 1'b0, 1'b0, 3'h0);
    step("crc kept");
    cfg(32'h1, 32'h1, 32'h2, 32'h0);
    frame(46, 60, 1'b0, 1'b0, 3'h0);
    step("preamble forward");
    cfg(32'h9, 32'h0, 32'h2, 32'h0);
    frame(10, 0, 1'b0, 1'b0, 3'h1);
    step("runt flag");
    cfg(32'h1, 32'h0, 32'h0, 32'h1);
    frame(5, 60, 1'b0, 1'b0, 3'h0);
    frame(50, 60, 1'b0, 1'b0, 3'h0);
    step("pad removal");
    apb(1'b1, 12'h4A0, 32'h40);
    cfg(32'h2A, 32'h0, 32'h2, 32'h0);
    frame(46, 60, 1'b0, 1'b0, 3'h0);
    frame(40, 60, 1'b1, 1'b1, 3'h0);
    frame(100, 60, 1'b0, 1'b1, 3'h0);
    frame(10, 0, 1'b0, 1'b1, 3'h0);
    frame(40, 60, 1'b0, 1'b0, 3'h0);
    step("store and forward");
    // each screen alone: pause, other control, then address match
    cfg(32'h4, 32'h0, 32'h2, 32'h0);
    ty = 16'h8808;
    op = 16'h0001;
    frame(44, 60, 1'b0, 1'b1, 3'h0);
    op = 16'h0002;
    frame(44, 60, 1'b0, 1'b0, 3'h0);
    cfg(32'h10, 32'h0, 32'h2, 32'h0);
    frame(44, 60, 1'b0, 1'b1, 3'h0);
    op = 16'h0001;
    frame(44, 60, 1'b0, 1'b0, 3'h0);
    ty = 16'h0000;
    apb(1'b1, 12'h500, 32'h1);
    da = 8'h02;
    frame(44, 60, 1'b0, 1'b1, 3'h0);
    da = 8'hFF;
    frame(44, 60, 1'b0, 1'b0, 3'h0);
    step("screens");
    apb(1'b0, 12'h4A4, 32'h0);
    chk(rd, 32'(nfr));
    apb(1'b0, 12'h4A8, 32'h0);
    chk(rd, 32'(nby));
    phy.send(frm, 1'b1);
    step("bad lead-in");
    give_verdict();
  end
endmodule
`default_nettype wire
